// file: rtl/sram_boundary_scan_tap.sv
// Purpose: Boundary-scan test port of a synchronous SRAM.
// Assumes: tck is the controller's test clock; clk is the SRAM clock.
// Notes: Capture only; the port never drives the core or preloads buffers.
//        Two clock domains: tck runs the scan logic, clk only the float level.
//        tck must give two rising edges after reset before the port responds.
`timescale 1ns/1ps
`include "sram_tap_cfg.svh"
module sram_boundary_scan_tap
  import sram_tap_pkg::*;
#(
  parameter int BSR_LEN = `BSR_LEN_X36,
  parameter logic [3:0] REV_CODE = 4'h1, // Arbitrary value
  parameter logic [4:0] DEPTH_CODE = 5'h0a, // Arbitrary value
  parameter logic [4:0] WIDTH_CODE = 5'h05, // Arbitrary value
  parameter logic [5:0] DEVICE_CODE = 6'h12, // Arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h2a5 // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [BSR_LEN-1:0] ioRing,
  output logic tdo,
  output logic tdoEn,
  output logic sramOutFloat
);

  // Identity word assembled from its fields
  localparam logic [`ID_WIDTH-1:0] ID_WORD = {REV_CODE, DEPTH_CODE, WIDTH_CODE,
    DEVICE_CODE, MAKER_CODE, 1'b1};

  // Reset release toward the test clock domain
  logic rstMeta_q; // First stage, read only by the second
  logic rstSync_q; // Synchronised active-high run enable

  // Controller state
  tapState_t state_q; // Current controller state
  tapState_t state_d; // Next controller state

  // Instruction path
  logic [`IR_WIDTH-1:0] irShift_q; // Serial instruction shifter
  instr_t instr_q; // Instruction in force

  // Data registers
  logic bypass_q; // Single bypass bit
  logic [`ID_WIDTH-1:0] idShift_q; // Identity shifter
  logic [BSR_LEN-1:0] bsrShift_q; // Boundary scan chain
  drSel_t drSel; // Selected data register
  // drSel follows instr_q, so it changes only at Update-IR or test reset

  // Pin ring sampled into the test clock domain
  logic [BSR_LEN-1:0] ringMeta_q; // First stage, read only by the second
  logic [BSR_LEN-1:0] ringSync_q; // Stable copy for capture

  // Float request and its crossing to the SRAM clock
  logic floatTck_q; // Float level in the test domain
  logic floatMeta_q; // First stage, read only by the second
  logic float_q; // Synchronised float level

  // Serial output, changed on the falling edge
  logic tdo_q;
  logic tdoEn_q;

  // Every test-domain register but this pair resets from rstSync_q, never from the raw pin.
  // Release the test domain from reset in step with tck.
  // Assertion is asynchronous so power-up leaves the port idle at once.
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Next-state logic of the sixteen-state controller.
  // Five rising edges with tms high reach Test-Logic-Reset from anywhere.
  always_comb begin
    // Hold by default; every state below assigns anyway
    state_d = state_q;
    unique case (state_q)
      // Parked in reset while tms stays high
      TEST_LOGIC_RESET: begin
        state_d = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      end
      // Idle between scans
      RUN_TEST_IDLE: begin
        state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
      end
      // Data register column
      // Choose between a data scan and the instruction column
      SELECT_DR: begin
        state_d = tms ? SELECT_IR : CAPTURE_DR;
      end
      // Selected data register loads its parallel value
      CAPTURE_DR: begin
        state_d = tms ? EXIT1_DR : SHIFT_DR;
      end
      // One bit per rising edge in this state, the exit edge with tms high included
      SHIFT_DR: begin
        state_d = tms ? EXIT1_DR : SHIFT_DR;
      end
      // Leave the data shift toward update or pause
      EXIT1_DR: begin
        state_d = tms ? UPDATE_DR : PAUSE_DR;
      end
      // Data shift suspended, register contents kept
      PAUSE_DR: begin
        state_d = tms ? EXIT2_DR : PAUSE_DR;
      end
      // Resume shifting or go to update
      EXIT2_DR: begin
        state_d = tms ? UPDATE_DR : SHIFT_DR;
      end
      // No update latches exist, so nothing happens here
      UPDATE_DR: begin
        state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
      end
      // Instruction register column
      // A further high tms leads back to reset
      SELECT_IR: begin
        state_d = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      end
      // Fixed pattern loads into the instruction shifter
      CAPTURE_IR: begin
        state_d = tms ? EXIT1_IR : SHIFT_IR;
      end
      // New code enters one bit per rising edge
      SHIFT_IR: begin
        state_d = tms ? EXIT1_IR : SHIFT_IR;
      end
      // Leave the instruction shift toward update or pause
      EXIT1_IR: begin
        state_d = tms ? UPDATE_IR : PAUSE_IR;
      end
      // Instruction shift suspended
      PAUSE_IR: begin
        state_d = tms ? EXIT2_IR : PAUSE_IR;
      end
      // Resume shifting or go to update
      EXIT2_IR: begin
        state_d = tms ? UPDATE_IR : SHIFT_IR;
      end
      // Shifted code becomes the instruction in force
      UPDATE_IR: begin
        state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
      end
    endcase
  end

  // Controller state register, sampled on the rising test clock
  // Asynchronous reset lands in Test-Logic-Reset, as power-up needs.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= TEST_LOGIC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Instruction shifter: fixed pattern at capture, tdi enters the MSB.
  // The upper bit is captured as zero; only the two LSBs come from the pattern.
  // Outside Capture-IR and Shift-IR the shifter keeps its contents.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      irShift_q <= `CODE_IDCODE;
    end else if (state_q == CAPTURE_IR) begin
      irShift_q <= {1'b0, `IR_CAPTURE_PATTERN};
    end else if (state_q == SHIFT_IR) begin
      irShift_q <= {tdi, irShift_q[`IR_WIDTH-1:1]};
    end
  end

  // Instruction in force: changes only at Update-IR or Test-Logic-Reset, so shifting
  // never disturbs the running test or the SRAM outputs.
  // Test-Logic-Reset has priority; the two states never coincide anyway.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      instr_q <= INSTR_IDCODE;
    end else if (state_q == TEST_LOGIC_RESET) begin
      instr_q <= INSTR_IDCODE;
    end else if (state_q == UPDATE_IR) begin
      instr_q <= instr_t'(irShift_q);
    end
  end

  // Data register selection by instruction.
  // Reserved codes fall to the bypass bit, a harmless path.
  // The controller is not meant to load them; this only keeps tdo defined.
  always_comb begin
    unique case (instr_q)
      INSTR_EXTEST: drSel = SEL_BSR;
      INSTR_IDCODE: drSel = SEL_ID;
      INSTR_SAMPLEZ: drSel = SEL_BSR;
      INSTR_SAMPLE: drSel = SEL_BSR;
      INSTR_BYPASS: drSel = SEL_BYPASS;
      INSTR_RSVD3, INSTR_RSVD5, INSTR_RSVD6: drSel = SEL_BYPASS;
    endcase
  end

  // Pin ring into the test domain through two flip-flops.
  // Bits may be caught mid-transition; the fast SRAM clock bit is
  // only meaningful if that clock was stopped or slowed.
  // The pair costs two tck cycles of latency, traded for a clean capture.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ringMeta_q <= '0;
      ringSync_q <= '0;
    end else begin
      ringMeta_q <= ioRing;
      ringSync_q <= ringMeta_q;
    end
  end

  // Bypass bit: cleared at capture, shifts tdi through
  // Capturing zero gives a known first bit on tdo in bypass.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      bypass_q <= 1'b0;
    end else if (drSel == SEL_BYPASS && state_q == CAPTURE_DR) begin
      bypass_q <= 1'b0;
    end else if (drSel == SEL_BYPASS && state_q == SHIFT_DR) begin
      bypass_q <= tdi;
    end
  end

  // Identity shifter: hardwired word at capture, LSB leaves first
  // The word is a constant, so capture needs no synchroniser.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      idShift_q <= '0;
    end else if (drSel == SEL_ID && state_q == CAPTURE_DR) begin
      idShift_q <= ID_WORD;
    end else if (drSel == SEL_ID && state_q == SHIFT_DR) begin
      idShift_q <= {tdi, idShift_q[`ID_WIDTH-1:1]};
    end
  end

  // Boundary scan chain: snapshot at capture, shift in Shift-DR.
  // Update-DR loads nothing, so it acts just like Pause-DR, and the
  // chain has no path back to the pins or the core.
  // Only a snapshot is held; there are no update latches to preload.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      bsrShift_q <= '0;
    end else if (drSel == SEL_BSR && state_q == CAPTURE_DR) begin
      bsrShift_q <= ringSync_q;
    end else if (drSel == SEL_BSR && state_q == SHIFT_DR) begin
      bsrShift_q <= {tdi, bsrShift_q[BSR_LEN-1:1]};
    end
  end

  // Float request: level held while a floating instruction is in force
  // Registered once in tck so the crossing starts from a flip-flop,
  // at the price of one extra test clock before the outputs float.
  always_ff @(posedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      floatTck_q <= 1'b0;
    end else begin
      floatTck_q <= (instr_q == INSTR_EXTEST) || (instr_q == INSTR_SAMPLEZ);
    end
  end

  // Serial output on the falling edge; driven only while shifting.
  // Reset keeps the pin released so power-up leaves it high-impedance.
  // Falling-edge launch gives the controller half a period of setup.
  always_ff @(negedge tck or negedge rstSync_q) begin
    if (!rstSync_q) begin
      tdo_q <= 1'b0;
      tdoEn_q <= 1'b0;
    end else begin
      tdoEn_q <= (state_q == SHIFT_IR) || (state_q == SHIFT_DR);
      // Shift-IR shows the instruction shifter, else the selected register
      if (state_q == SHIFT_IR) begin
        tdo_q <= irShift_q[0];
      end else if (drSel == SEL_ID) begin
        tdo_q <= idShift_q[0];
      end else if (drSel == SEL_BSR) begin
        tdo_q <= bsrShift_q[0];
      end else begin
        tdo_q <= bypass_q;
      end
    end
  end

  // Float level crosses to the SRAM clock through two flip-flops.
  // A level suffices: it changes only at Update-IR or test reset.
  // Its reset follows the pin directly, so SRAM outputs recover at once.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      floatMeta_q <= 1'b0;
      float_q <= 1'b0;
    end else begin
      floatMeta_q <= floatTck_q;
      float_q <= floatMeta_q;
    end
  end

  // Outputs straight from flip-flops
  // tdoEn is the pad's output enable; tdo itself never goes high-impedance here.
  assign tdo = tdo_q;
  assign tdoEn = tdoEn_q;
  assign sramOutFloat = float_q;

endmodule : sram_boundary_scan_tap

// file: pkg/sram_tap_cfg.svh
// Purpose: Constants for the SRAM boundary-scan test port.
// Assumes: Included by bare name; definitions only.
// Notes: Field positions and codes of the scan registers.
`ifndef SRAM_TAP_CFG_SVH
`define SRAM_TAP_CFG_SVH
`define IR_WIDTH 3
`define ID_WIDTH 32
`define CODE_EXTEST 3'h0
`define CODE_IDCODE 3'h1
`define CODE_SAMPLEZ 3'h2
`define CODE_SAMPLE 3'h4
`define CODE_BYPASS 3'h7
`define IR_CAPTURE_PATTERN 2'h1
`define BSR_LEN_X18 52
`define BSR_LEN_X32 67
`define BSR_LEN_X36 71
`define ID_REV_MSB 31
`define ID_REV_LSB 28
`define ID_DEPTH_MSB 27
`define ID_DEPTH_LSB 23
`define ID_WIDTH_MSB 22
`define ID_WIDTH_LSB 18
`define ID_DEV_MSB 17
`define ID_DEV_LSB 12
`define ID_MAKER_MSB 11
`define ID_MAKER_LSB 1
`define ID_PRESENT_BIT 0
`define RESET_TMS_EDGES 5
`endif

// file: pkg/sram_tap_pkg.sv
// Purpose: Types for the SRAM boundary-scan test port.
// Assumes: Codes match the constants header.
// Notes: Controller states use our own binary encoding.
package sram_tap_pkg;
  // Sixteen controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET = 4'h0,
    RUN_TEST_IDLE = 4'h1,
    SELECT_DR = 4'h2,
    CAPTURE_DR = 4'h3,
    SHIFT_DR = 4'h4,
    EXIT1_DR = 4'h5,
    PAUSE_DR = 4'h6,
    EXIT2_DR = 4'h7,
    UPDATE_DR = 4'h8,
    SELECT_IR = 4'h9,
    CAPTURE_IR = 4'ha,
    SHIFT_IR = 4'hb,
    EXIT1_IR = 4'hc,
    PAUSE_IR = 4'hd,
    EXIT2_IR = 4'he,
    UPDATE_IR = 4'hf
  } tapState_t;
  // Instruction codes, reserved ones included
  typedef enum logic [2:0] {
    INSTR_EXTEST = 3'h0,
    INSTR_IDCODE = 3'h1,
    INSTR_SAMPLEZ = 3'h2,
    INSTR_RSVD3 = 3'h3,
    INSTR_SAMPLE = 3'h4,
    INSTR_RSVD5 = 3'h5,
    INSTR_RSVD6 = 3'h6,
    INSTR_BYPASS = 3'h7
  } instr_t;
  // Which data register sits in the serial path
  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_ID = 2'h1,
    SEL_BSR = 2'h2
  } drSel_t;
endpackage : sram_tap_pkg

// file: dv/sram_tap_asserts.sv
// Purpose: Pin-level checks of the scan port.
// Assumes: Sees the top ports only.
// Notes: Shift state is read back from tdoEn.
`timescale 1ns/1ps
module sram_tap_asserts (
  input logic clk,
  input logic reset_n,
  input logic tck,
  input logic tms,
  input logic tdi,
  input logic tdoEn,
  input logic sramOutFloat
);
  logic [2:0] tmsRun_q; // Run of high mode-select edges
  logic [2:0] sh_q; // Last three bits shifted in
  logic tapRst; // Controller sits in its reset state
  assign tapRst = tmsRun_q >= 3'h5;
  // Saturating run; power-up counts as a reset
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) tmsRun_q <= 3'h5;
    else if (!tms) tmsRun_q <= 3'h0;
    else if (!tapRst) tmsRun_q <= tmsRun_q + 3'h1;
  end
  // After an instruction scan this holds the new code
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) sh_q <= 3'h1;
    else if (tdoEn) sh_q <= {tdi, sh_q[2:1]};
  end
  property p_shiftNeedsLow; @(posedge tck) disable iff (!reset_n) tms |=> !tdoEn; endproperty
  a_shiftNeedsLow: assert property (p_shiftNeedsLow) else $error("data out after high select");
  property p_shiftHolds; @(posedge tck) disable iff (!reset_n) tdoEn && !tms |=> tdoEn; endproperty
  a_shiftHolds: assert property (p_shiftHolds) else $error("shift left with low select");
  property p_resetQuiet; @(posedge tck) disable iff (!reset_n) tms [*5] |=> !tdoEn [*4]; endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("data out too soon after reset");
  // Sync delay spans a few system clocks, so the bound is loose
  property p_floatClears; @(posedge clk) disable iff (!reset_n) tapRst |-> ##[0:16] !sramOutFloat; endproperty
  a_floatClears: assert property (p_floatClears) else $error("float kept in reset");
  property p_floatRise; @(posedge clk) disable iff (!reset_n) $rose(sramOutFloat) |-> sh_q == 3'h0 ||
    sh_q == 3'h2; endproperty
  a_floatRise: assert property (p_floatRise) else $error("float without cause");
  property p_floatFall; @(posedge clk) disable iff (!reset_n) $fell(sramOutFloat) |-> tapRst ||
    (sh_q != 3'h0 && sh_q != 3'h2); endproperty
  a_floatFall: assert property (p_floatFall) else $error("float dropped early");
  property p_floatHolds; @(posedge clk) disable iff (!reset_n) sramOutFloat && !tapRst &&
    (sh_q == 3'h0 || sh_q == 3'h2) |=> sramOutFloat; endproperty
  a_floatHolds: assert property (p_floatHolds) else $error("float not held");
  property p_releaseQuiet; @(posedge clk) disable iff (!reset_n) $rose(reset_n) |-> !sramOutFloat; endproperty
  a_releaseQuiet: assert property (p_releaseQuiet) else $error("float up at release");
endmodule : sram_tap_asserts
bind sram_boundary_scan_tap sram_tap_asserts u_asserts (.clk(clk), .reset_n(reset_n), .tck(tck),
  .tms(tms), .tdi(tdi), .tdoEn(tdoEn), .sramOutFloat(sramOutFloat));

// file: dv/scan_ctl.sv
// Purpose: Board test controller model.
// Assumes: Tasks are called one at a time.
// Notes: Test clock runs only inside tasks, 80 ns period.
`timescale 1ns/1ps
module scan_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input logic tdo,
  input logic tdoEn
);
  // Pins rest at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One clock: inputs set while low, output taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40 tck = 1'b1;
    o = tdoEn ? tdo : ~tdo; // Released pin has no pull; show the inverse
    #40 tck = 1'b0;
  endtask : step
  // More than five high edges, then idle
  task automatic tap_reset();
    logic o;
    repeat (10) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask : tap_reset
  // Idle clocks; data line toggles so nothing stale is seen
  task automatic idle(input int n);
    logic o;
    repeat (n) step(1'b0, ~tdi, o);
  endtask : idle
  // Walk to shift, shift n bits LSB first, update, return to idle
  task automatic scan(input logic ir, input int n, input logic [79:0] di, output logic [79:0] dq);
    logic o;
    dq = '0;
    step(1'b1, ~tdi, o);
    if (ir) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i], o);
      dq[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask : scan
endmodule : scan_ctl

// file: dv/sram_boundary_scan_tap_tb.sv
// Purpose: Self-checking bench for the scan port.
// Assumes: Design keeps its default identity fields.
// Notes: Reference path pushes bits through a queue.
`timescale 1ns/1ps
`include "sram_tap_cfg.svh"
module sram_boundary_scan_tap_tb;
  localparam int L = `BSR_LEN_X36; // Ring length under test
  localparam logic [31:0] ID_WORD = {4'h1, 5'h0a, 5'h05, 6'h12, 11'h2a5, 1'b1}; // Arbitrary fields
  logic clk, reset_n, tck, tms, tdi, tdo, tdoEn, sramOutFloat; // Pins
  logic [L-1:0] ioRing; // Pin ring seen by the port
  logic [79:0] got; // Bits read back
  logic [15:0] seed = 16'h002e; // Random state
  int miscompares = 0; // Mismatches
  int comparisons = 0; // Compares made
  sram_boundary_scan_tap #(.BSR_LEN(L)) DUT (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms),
    .tdi(tdi), .ioRing(ioRing), .tdo(tdo), .tdoEn(tdoEn), .sramOutFloat(sramOutFloat));
  scan_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));
  // System clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Captured bits leave first, shifted-in bits follow
  function automatic logic [79:0] model(input int n, input logic [79:0] cap, input int len, input logic [79:0] din);
    logic q[$];
    logic [79:0] r;
    r = '0;
    for (int i = 0; i < len; i++) q.push_back(cap[i]);
    for (int i = 0; i < n; i++) begin
      r[i] = q.pop_front();
      q.push_back(din[i]);
    end
    return r;
  endfunction : model
  task automatic check(input logic [79:0] seen, input logic [79:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic fill(output logic [79:0] v);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      v[16*i+:16] = seed;
    end
  endtask : fill
  // Load an instruction; the old shifter shows the capture pattern
  task automatic ir(input logic [2:0] c);
    ctl.scan(1'b1, 3, {77'h0, c}, got);
    check(got, model(3, 80'h1, 3, 80'h0));
    ctl.idle(2);
  endtask : ir
  // Ring held still across capture, so every bit is comparable
  task automatic dr(input logic [2:0] c);
    logic [79:0] r;
    logic [79:0] d;
    fill(r);
    fill(d);
    @(negedge clk);
    ioRing = r[L-1:0];
    ctl.scan(1'b0, L + 8, d, got);
    if (c == 3'h1) check(got, model(L + 8, {48'h0, ID_WORD}, 32, d));
    else if (c == 3'h0 || c == 3'h2 || c == 3'h4) check(got, model(L + 8, r, L, d));
    else check(got, model(L + 8, 80'h0, 1, d));
    @(negedge clk);
    check(sramOutFloat, c == 3'h0 || c == 3'h2);
  endtask : dr
  task automatic print_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Every non-reserved code in turn, code 000 twice, then both kinds of reset
  initial begin
    reset_n = 1'b0;
    ioRing = '0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    ctl.tap_reset();
    dr(3'h1);
    for (int c = 0; c < 9; c++) begin
      // Reserved codes are never loaded; bypass runs in their place
      ir((c == 3 || c == 5 || c == 6) ? 3'h7 : c[2:0]);
      dr((c == 3 || c == 5 || c == 6) ? 3'h7 : c[2:0]);
    end
    ctl.tap_reset();
    dr(3'h1);
    ir(3'h2);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    check(sramOutFloat, 80'h0);
    reset_n = 1'b1;
    ctl.tap_reset();
    dr(3'h1);
    print_verdict();
  end
endmodule : sram_boundary_scan_tap_tb
